//--- sac_core.sv
// Purpose: control side of a 12-bit successive-approximation converter
// Assumes: comparator output cmp_above is synchronous to mclk and settled per period
// Notes:   a set go starts bits only at conversion-bit period boundaries; clearing go aborts in any mclk cycle but the first and the completing one
//
// How it works
// [RQ1] successive approximation builds 12 bits, stored into the result byte pair
// [RQ2] one sample-and-hold; channel select steers which input feeds it
// [RQ3] software waits a settling delay after changing channel before starting
// [RQ4] clock select picks system clock divide by 8, 16, 32 or 128
// [RQ5] one bit per period; whole conversion spans 16 periods
// [RQ6] software picks a divider that meets the bit period specification
// [RQ7] divider periods follow the system clock; only rc source is independent
// [RQ8] done flag sets at every conversion end, interrupt enabled or not
// [RQ9] interrupt request is done flag and its enable both set
// [RQ10] hardware never clears done flag; software clears it
// [RQ11] done interrupt works in run and sleep; it wakes a sleeping device
// [RQ12] after wake, next instruction first, then isr only with global enable
// [RQ13] align select low gives left 12 bits, high gives right 10 bits
// [RQ14] software sets pin direction to input before analog conversion
// [RQ15] software enables converter first, sets go in a later write
// [RQ16] on completion go clears, done flag sets, result pair loads
// [RQ17] clearing go mid-conversion aborts, keeps result, then waits 2 periods
// [RQ18] rc source waits one instruction cycle; other sources abort on sleep
// [RQ19] both result bytes change in the same clock cycle
// [RQ20] go enters on a period boundary; completion returns on mclk
`timescale 1ns/1ps
module sac_core
  import sac_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire sac_ctrl_t         ctrl,
  input  wire logic              go_set,
  input  wire logic              go_clear,
  input  wire logic              done_clear,
  input  wire logic              sleep_mode,
  input  wire logic              global_irq_enable,
  input  wire logic              rc_tick,
  input  wire logic              cmp_above,
  output logic                   go_busy,
  output logic                   conv_done_flag,
  output logic                   irq_request,
  output logic                   wake_request,
  output logic                   isr_branch,
  output logic                   converter_powered,
  output logic                   sh_sample,
  output logic [CHAN_W-1:0]      sh_channel,
  output logic [RES_W-1:0]       dac_code,
  output sac_result_t            result
);

  typedef struct packed {
    sac_state_t        st;
    logic [PER_W-1:0]  per;
    logic [ICNT_W-1:0] icnt;
    logic [RES_W-1:0]  sar;
    logic [RES_W-1:0]  dac;
    logic              go;
    logic              done;
    logic              en_prev;
    logic              shut;
    logic [CHAN_W-1:0] chan;
    sac_result_t       res;
  } sac_core_state_t;

  sac_core_state_t s_q;
  sac_core_state_t s_d;
  logic            bit_tick;
  logic            powered;
  logic            done_evt;
  logic [RES_W-1:0] sar_new;
  logic [3:0]       bit_idx;

  sac_bit_clock u_bit_clock (
    .mclk              (mclk),
    .rst               (rst),
    .conv_clock_select (ctrl.conv_clock_select),
    .use_internal_rc   (ctrl.use_internal_rc),
    .rc_tick           (rc_tick),
    .bit_tick          (bit_tick)
  );

  function automatic sac_result_t sac_format(input logic [RES_W-1:0] r,
                                             input logic             right);
    sac_result_t f;
    if (right) begin
      // right aligned keeps only the top ten conversion bits
      f.result_high_byte_reg = {6'h00, r[RES_W-1 -: 2]};
      f.result_low_byte      = r[RES_W-3 -: 8];
    end else begin
      f.result_high_byte_reg = r[RES_W-1 -: 8];
      f.result_low_byte      = {r[3:0], 4'h0};
    end
    return f;
  endfunction : sac_format

  assign powered = ctrl.converter_enable && !s_q.shut;
  assign bit_idx = 4'(PER_BIT_HI - s_q.per);

  always_comb begin
    s_d      = s_q;
    done_evt = 1'b0;
    sar_new  = s_q.sar;
    s_d.en_prev = ctrl.converter_enable;
    s_d.chan    = ctrl.channel_select; // RQ2

    // go only when the converter was already on before this write
    if (go_set && s_q.en_prev && ctrl.converter_enable) begin
      s_d.go = 1'b1; // RQ15
    end

    case (s_q.st)
      ST_IDLE: begin
        s_d.per = '0;
        if (s_q.go && powered) begin
          s_d.icnt = '0;
          s_d.st   = ctrl.use_internal_rc ? ST_RC_DELAY : ST_ARM;
        end
      end
      ST_RC_DELAY: begin
        // lets the cpu enter sleep before the noisy bit sequence starts
        s_d.icnt = s_q.icnt + 3'h1;
        if (s_q.icnt == ICNT_LAST) begin
          s_d.st = ST_ARM; // RQ18
        end
      end
      ST_ARM: begin
        // start is aligned to a period edge of the conversion clock
        if (bit_tick) begin
          s_d.st  = ST_CONVERT; // RQ20
          s_d.per = '0;
          s_d.sar = RES_RST;
          s_d.dac = RES_RST;
        end
      end
      ST_CONVERT: begin
        if (bit_tick) begin
          s_d.per = s_q.per + 4'h1;
          if (s_q.per == PER_MSB_TRY) begin
            s_d.dac = MSB_TRIAL;
          end
          if (s_q.per >= PER_BIT_LO && s_q.per <= PER_BIT_HI) begin
            sar_new[bit_idx] = cmp_above; // RQ1 RQ5
            s_d.sar = sar_new;
            s_d.dac = sar_new;
            if (s_q.per != PER_BIT_HI) begin
              s_d.dac[bit_idx - 4'h1] = 1'b1;
            end
          end
          if (s_q.per == PER_LAST) begin
            done_evt = 1'b1; // RQ5 RQ16
            s_d.st   = ST_IDLE;
            s_d.go   = 1'b0; // RQ16
            // one struct write so both bytes move together
            s_d.res  = sac_format(s_q.sar, ctrl.result_align_select); // RQ13 RQ19
          end
        end
      end
      ST_ABORT_WAIT: begin
        // sampling stays off until two periods have passed
        if (bit_tick) begin
          s_d.per = s_q.per + 4'h1;
          if (s_q.per == PER_ABORT) begin
            s_d.st = ST_IDLE; // RQ17
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    if (s_q.st == ST_CONVERT || s_q.st == ST_RC_DELAY || s_q.st == ST_ARM) begin
      if (go_clear && !done_evt) begin
        s_d.st  = ST_ABORT_WAIT; // RQ17
        s_d.per = '0;
        s_d.go  = 1'b0;
      end
    end else if (go_clear) begin
      s_d.go = 1'b0;
    end

    // leaving sleep lifts the shutdown caused by it
    if (!sleep_mode) begin
      s_d.shut = 1'b0;
    end else if (!ctrl.use_internal_rc) begin
      s_d.shut = 1'b1; // RQ18
    end else if (done_evt && !ctrl.conv_irq_enable) begin
      s_d.shut = 1'b1;
    end

    if (!powered || s_d.shut) begin
      s_d.st = ST_IDLE; // RQ18
      s_d.go = 1'b0;
    end

    // set wins over a clear in the same cycle; only done_clear or rst clears it
    if (done_evt) begin
      s_d.done = 1'b1; // RQ8 RQ10
    end else if (done_clear) begin
      s_d.done = 1'b0;
    end

  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q.st      <= ST_IDLE;
      s_q.per     <= '0;
      s_q.icnt    <= '0;
      s_q.sar     <= RES_RST;
      s_q.dac     <= RES_RST;
      s_q.go      <= 1'b0;
      s_q.done    <= 1'b0;
      s_q.en_prev <= 1'b0;
      s_q.shut    <= 1'b0;
      s_q.chan    <= '0;
      s_q.res     <= {BYTE_RST, BYTE_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign go_busy           = s_q.go;
  assign conv_done_flag    = s_q.done;
  assign irq_request       = s_q.done && ctrl.conv_irq_enable; // RQ9
  assign wake_request      = irq_request && sleep_mode; // RQ11
  // no branch while asleep; once awake the cpu runs its next instruction first
  assign isr_branch        = irq_request && global_irq_enable && !sleep_mode; // RQ12
  assign converter_powered = powered;
  assign sh_sample         = powered && (s_q.st == ST_IDLE); // RQ2 RQ17
  assign sh_channel        = s_q.chan; // RQ2
  assign dac_code          = s_q.dac;
  assign result            = s_q.res;

endmodule : sac_core

//--- sac_pkg.sv
// Purpose: shared constants and carrier types of the sar converter control
// Assumes: one clock, mclk; conversion clock appears as a one-cycle tick
// Notes:   offsets, counts and reset values live here only
package sac_pkg;

  localparam int unsigned RES_W          = 12;
  localparam int unsigned CHAN_W         = 5;
  localparam int unsigned CLKSEL_W       = 2;
  localparam int unsigned CONV_PERIODS   = 16;
  localparam int unsigned HOLD_PERIODS   = 2;
  localparam int unsigned ABORT_PERIODS  = 2;
  localparam int unsigned RIGHT_BITS     = 10;
  localparam int unsigned PER_W          = $clog2(CONV_PERIODS);
  localparam int unsigned DIV_W          = 8;

  // one instruction cycle is four system clocks
  localparam int unsigned INSTR_CLKS     = 4;
  localparam int unsigned ICNT_W         = 3;

  localparam logic [CLKSEL_W-1:0] CLK_DIV8   = 2'h0;
  localparam logic [CLKSEL_W-1:0] CLK_DIV16  = 2'h1;
  localparam logic [CLKSEL_W-1:0] CLK_DIV32  = 2'h2;
  localparam logic [CLKSEL_W-1:0] CLK_DIV128 = 2'h3;

  localparam logic [DIV_W-1:0] DIV8   = 8'h08;
  localparam logic [DIV_W-1:0] DIV16  = 8'h10;
  localparam logic [DIV_W-1:0] DIV32  = 8'h20;
  localparam logic [DIV_W-1:0] DIV128 = 8'h80;

  localparam logic [PER_W-1:0] PER_LAST     = 4'hf;
  localparam logic [PER_W-1:0] PER_MSB_TRY  = 4'h1;
  localparam logic [PER_W-1:0] PER_BIT_LO   = 4'h2;
  localparam logic [PER_W-1:0] PER_BIT_HI   = 4'hd;
  localparam logic [PER_W-1:0] PER_ABORT    = 4'h1;
  localparam logic [ICNT_W-1:0] ICNT_LAST   = 3'h3;
  localparam logic [RES_W-1:0] RES_RST      = 12'h000;
  localparam logic [RES_W-1:0] MSB_TRIAL    = 12'h800;
  localparam logic [7:0]       BYTE_RST     = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RC_DELAY,
    ST_ARM,
    ST_CONVERT,
    ST_ABORT_WAIT
  } sac_state_t;

  typedef struct packed {
    logic                converter_enable;
    logic [CLKSEL_W-1:0] conv_clock_select;
    logic                use_internal_rc;
    logic [CHAN_W-1:0]   channel_select;
    logic                result_align_select;
    logic                conv_irq_enable;
  } sac_ctrl_t;

  typedef struct packed {
    logic [7:0] result_high_byte_reg;
    logic [7:0] result_low_byte;
  } sac_result_t;

  function automatic logic [DIV_W-1:0] sac_div_of(input logic [CLKSEL_W-1:0] sel);
    case (sel)
      CLK_DIV8:  sac_div_of = DIV8;
      CLK_DIV16: sac_div_of = DIV16;
      CLK_DIV32: sac_div_of = DIV32;
      default:   sac_div_of = DIV128;
    endcase
  endfunction : sac_div_of

endpackage : sac_pkg

//--- sac_bit_clock.sv
// Purpose: conversion-bit period tick from a system clock divider or the rc clock
// Assumes: rc_tick is a one-cycle strobe already in the mclk domain
// Notes:   divider restarts on a select change so the first period is never short
`timescale 1ns/1ps
module sac_bit_clock
  import sac_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [CLKSEL_W-1:0] conv_clock_select,
  input  wire logic                use_internal_rc,
  input  wire logic                rc_tick,
  output logic                     bit_tick
);

  typedef struct packed {
    logic [DIV_W-1:0]    cnt;
    logic [CLKSEL_W-1:0] sel;
    logic                tick;
  } sac_div_state_t;

  sac_div_state_t s_q;
  sac_div_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.sel  = conv_clock_select;
    s_d.tick = 1'b0;
    if (use_internal_rc) begin
      // only this source is independent of the system clock
      s_d.cnt  = '0;
      s_d.tick = rc_tick; // RQ7
    end else if (s_q.sel != conv_clock_select) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == sac_div_of(conv_clock_select) - 8'h01) begin
      // period tracks mclk, so any system clock change moves it too
      s_d.cnt  = '0;
      s_d.tick = 1'b1; // RQ4 RQ7
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_tick = s_q.tick;

endmodule : sac_bit_clock

//--- sac_core_assertions.sv
// Purpose: port checker for the converter control
// Assumes: one mclk domain, rst synchronous active high
// Notes:   irq outputs are combinational, so they are checked every cycle
`timescale 1ns/1ps
module sac_core_assertions
  import sac_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire sac_ctrl_t         ctrl,
  input wire logic              go_set,
  input wire logic              go_clear,
  input wire logic              done_clear,
  input wire logic              sleep_mode,
  input wire logic              global_irq_enable,
  input wire logic              go_busy,
  input wire logic              conv_done_flag,
  input wire logic              irq_request,
  input wire logic              wake_request,
  input wire logic              isr_branch,
  input wire logic              converter_powered,
  input wire logic [CHAN_W-1:0] sh_channel,
  input wire sac_result_t       result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  irq_gate_a: assert property (irq_request == (conv_done_flag & ctrl.conv_irq_enable))
    else $error("irq request wrong");
  wake_gate_a: assert property (wake_request == (irq_request & sleep_mode))
    else $error("wake request wrong");
  isr_gate_a: assert property (
    isr_branch == (irq_request & global_irq_enable & !sleep_mode)) else $error("isr wrong");
  flag_sticky_a: assert property (conv_done_flag && !done_clear |=> conv_done_flag)
    else $error("done flag lost");
  done_ends_go_a: assert property ($rose(conv_done_flag) |-> $fell(go_busy))
    else $error("done without go clear");
  result_load_a: assert property ($changed(result) |-> $fell(go_busy) && conv_done_flag)
    else $error("result changed outside completion");
  chan_route_a: assert property (1'b1 |=> sh_channel == $past(ctrl.channel_select))
    else $error("channel not routed");
  go_refuse_a: assert property (
    go_set && !go_busy && !$past(ctrl.converter_enable) |=> !go_busy) else $error("go taken");
  sleep_stop_a: assert property (sleep_mode && !ctrl.use_internal_rc |=>
    !converter_powered && !go_busy) else $error("no shutdown in sleep");
  abort_stop_a: assert property (go_clear && go_busy && $past(go_busy) |=> !go_busy)
    else $error("abort ignored");
  align_pad_a: assert property ($rose(conv_done_flag) |-> ctrl.result_align_select ?
    result.result_high_byte_reg[7:2] == 6'h0 : result.result_low_byte[3:0] == 4'h0)
    else $error("alignment padding wrong");
endmodule : sac_core_assertions

//--- sac_analog_model.sv
// Purpose: analog far side, two channel levels behind one sample-and-hold
// Assumes: comparator answers at once against the held level
// Notes:   level freezes while sampling is off, as a hold capacitor does
`timescale 1ns/1ps
module sac_analog_model
  import sac_pkg::*;
(
  input  wire logic                  mclk,
  // pins only ever feed the converter: set as analog inputs before use
  input  wire logic [1:0][RES_W-1:0] lv,
  input  wire logic                  sh_sample,
  input  wire logic [CHAN_W-1:0]     sh_channel,
  input  wire logic [RES_W-1:0]      dac_code,
  output logic                       cmp_above
);
  logic [RES_W-1:0] held_q;
  // only two inputs modelled, so upper select bits are ignored
  always @(posedge mclk) if (sh_sample) held_q <= lv[sh_channel[0]];
  assign cmp_above = (held_q >= dac_code);
endmodule : sac_analog_model

//--- tb_top.sv
// Purpose: self-checking bench for the converter control
// Assumes: rc strobe every 10 mclk when enabled
// Notes:   divider choice is judged from conversion length bounds
`timescale 1ns/1ps
module tb_top import sac_pkg::*;;
  logic mclk = 1'b0, rst = 1'b1, go_set = 1'b0, go_clear = 1'b0, done_clear = 1'b0;
  logic sleep_mode = 1'b0, gie = 1'b0, rc_tick = 1'b0, rc_on = 1'b0;
  logic              cmp_above, go_busy, flag, irq, wake, isr, pwr, sh_sample;
  sac_ctrl_t         ctrl = '0;
  logic [1:0][11:0]  lv = {12'h3c7, 12'ha5c};
  logic [CHAN_W-1:0] sh_channel;
  logic [RES_W-1:0]  dac_code;
  sac_result_t       result;
  logic [3:0]        rc_cnt = 4'h0;
  logic [15:0]       keep;
  int                num_errors = 0, cmp_count = 0, n;
  sac_core dut (.mclk(mclk), .rst(rst), .ctrl(ctrl), .go_set(go_set), .go_clear(go_clear),
    .done_clear(done_clear), .sleep_mode(sleep_mode), .global_irq_enable(gie),
    .rc_tick(rc_tick), .cmp_above(cmp_above), .go_busy(go_busy), .conv_done_flag(flag),
    .irq_request(irq), .wake_request(wake), .isr_branch(isr), .converter_powered(pwr),
    .sh_sample(sh_sample), .sh_channel(sh_channel), .dac_code(dac_code), .result(result));
  sac_analog_model far (.mclk(mclk), .lv(lv), .sh_sample(sh_sample),
    .sh_channel(sh_channel), .dac_code(dac_code), .cmp_above(cmp_above));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    rc_cnt  <= (rc_cnt == 4'h9) ? 4'h0 : rc_cnt + 4'h1;
    rc_tick <= rc_on && rc_cnt == 4'h9;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  // a stuck wait is a failure, never a hang
  task automatic wait_for(input int lim, input bit on_flag);
    n = 0;
    // outputs are read at the falling edge, where they have settled
    @(negedge mclk);
    while ((on_flag ? flag : sh_sample) !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_for
  function automatic logic [15:0] fmt(input logic [11:0] l, input logic al);
    return al ? {6'h0, l[11:2]} : {l, 4'h0};
  endfunction : fmt
  task automatic start(input logic [1:0] sel, input logic al, input logic ch);
    tick(1);
    ctrl.conv_clock_select   <= sel;
    ctrl.result_align_select <= al;
    ctrl.channel_select      <= {4'h0, ch};
    done_clear               <= 1'b1;
    tick(1);
    done_clear <= 1'b0;
    tick(3);
    go_set <= 1'b1;
    tick(1);
    go_set <= 1'b0;
  endtask : start
  task automatic conv(input logic [1:0] sel, input logic al, input logic ch, input int np,
                      input logic slp);
    start(sel, al, ch);
    sleep_mode <= slp;
    wait_for(20 * np, 1'b1);
    chk("conv_len", 16'(n >= 16 * np && n <= 17 * np + 8), 16'h1);
    chk("result", result, fmt(lv[ch], al));
    chk("go_busy", go_busy, 16'h0);
    chk("irq", irq, ctrl.conv_irq_enable);
  endtask : conv
  task automatic t_refuse();
    tick(1);
    ctrl.converter_enable <= 1'b1;
    go_set                <= 1'b1;
    tick(1);
    go_set <= 1'b0;
    tick(2);
    @(negedge mclk);
    chk("go_refused", go_busy, 16'h0);
  endtask : t_refuse
  task automatic t_modes();
    for (int s = 0; s < 4; s++) conv(2'(s), s[0], s[1], 8 << (s == 3 ? 4 : s), 1'b0);
  endtask : t_modes
  task automatic t_flag();
    tick(20);
    ctrl.conv_irq_enable <= 1'b1;
    gie                  <= 1'b1;
    @(negedge mclk);
    chk("flag_sticky", flag, 16'h1);
    chk("isr", isr, 16'h1);
    tick(1);
    sleep_mode <= 1'b1;
    @(negedge mclk);
    chk("wake", wake, 16'h1);
    chk("isr_asleep", isr, 16'h0);
    tick(1);
    sleep_mode <= 1'b0;
    done_clear <= 1'b1;
    tick(1);
    done_clear <= 1'b0;
    @(negedge mclk);
    chk("flag_clear", flag, 16'h0);
  endtask : t_flag
  task automatic t_abort();
    keep = result;
    start(2'h0, 1'b0, 1'b1);
    tick(40);
    go_clear <= 1'b1;
    tick(1);
    go_clear <= 1'b0;
    @(negedge mclk);
    chk("abort_busy", go_busy, 16'h0);
    wait_for(40, 1'b0);
    chk("abort_gap", 16'(n >= 8), 16'h1);
    chk("abort_result", result, keep);
    chk("abort_flag", flag, 16'h0);
  endtask : t_abort
  task automatic t_sleep();
    start(2'h0, 1'b1, 1'b0);
    tick(40);
    sleep_mode <= 1'b1;
    tick(1);
    @(negedge mclk);
    chk("sleep_busy", go_busy, 16'h0);
    chk("sleep_power", pwr, 16'h0);
    tick(1);
    sleep_mode <= 1'b0;
    wait_for(40, 1'b0);
    chk("sleep_result", result, keep);
  endtask : t_sleep
  task automatic t_rc();
    tick(1);
    rc_on                <= 1'b1;
    ctrl.use_internal_rc <= 1'b1;
    conv(2'h0, 1'b0, 1'b0, 10, 1'b1);
    chk("rc_wake", wake, 16'h1);
    // with its interrupt off, an rc conversion in sleep ends in shutdown
    tick(1);
    ctrl.conv_irq_enable <= 1'b0;
    conv(2'h0, 1'b1, 1'b1, 10, 1'b1);
    chk("rc_shut", pwr, 16'h0);
    chk("rc_no_wake", wake, 16'h0);
    tick(1);
    sleep_mode <= 1'b0;
  endtask : t_rc
  initial begin
    tick(4);
    rst <= 1'b0;
    t_refuse();
    t_modes();
    t_flag();
    t_abort();
    t_sleep();
    t_rc();
    tally_and_finish();
  end
endmodule : tb_top
bind sac_core sac_core_assertions u_chk (.mclk(mclk), .rst(rst), .ctrl(ctrl),
  .go_set(go_set), .go_clear(go_clear), .done_clear(done_clear), .sleep_mode(sleep_mode),
  .global_irq_enable(global_irq_enable), .go_busy(go_busy), .conv_done_flag(conv_done_flag),
  .irq_request(irq_request), .wake_request(wake_request), .isr_branch(isr_branch),
  .converter_powered(converter_powered), .sh_channel(sh_channel), .result(result));
